/* File: logic/wtc_consts.svh */
// constants for the weight tolerance classifier: offsets, fields, resets
// assumes a 32-bit plain register port and 25-bit signed weight samples
//
// Contract
// (RULE1) loaded record is compared continuously, no start
// (RULE2) filling: inside band, only ok asserted
// (RULE3) filling: above upper limit, only over asserted
// (RULE4) filling: below lower limit, only under asserted
// (RULE5) exact limits: above over limit is over
// (RULE6) exact limits: below under limit is under
// (RULE7) deviation: target plus/minus fixed tolerances
// (RULE8) percent: limit is target plus/minus tol*target/100
// (RULE9) motion check on: outputs only at no-motion
// (RULE10) motion check off: outputs follow weight dynamically
// (RULE11) record selects net or gross weight
// (RULE12) mode is over/under or manual filling
// (RULE13) external inputs may trigger progress display
// (RULE14) deviation fixed, percent band scales with target
`ifndef WTC_CONSTS_SVH
`define WTC_CONSTS_SVH

// ----------------
// widths
// ----------------
`define WTC_WT_W        24
`define WTC_TOL_W       24
`define WTC_ADDR_W      8
`define WTC_DATA_W      32
`define WTC_PCT_DIV     40'd100

// ----------------
// register byte offsets
// ----------------
`define WTC_OFS_CTRL    8'h00
`define WTC_OFS_TARGET  8'h04
`define WTC_OFS_TOL_POS 8'h08
`define WTC_OFS_TOL_NEG 8'h0c
`define WTC_OFS_LOAD    8'h10
`define WTC_OFS_STATUS  8'h14
`define WTC_OFS_IRQ_ST  8'h18
`define WTC_OFS_IRQ_MSK 8'h1c

// ----------------
// control fields and reset values
// ----------------
`define WTC_CTRL_MODE   0
`define WTC_CTRL_TOL_LO 1
`define WTC_CTRL_TOL_HI 2
`define WTC_CTRL_SRC    3
`define WTC_CTRL_MCHK   4
`define WTC_CTRL_RST    5'h00
`define WTC_LOAD_GO     0
`define WTC_LOAD_CLR    1

`endif

/* File: logic/wtc_pkg.sv */
// types shared by the weight tolerance classifier files
// assumes wtc_consts.svh is on the include path
`default_nettype none
package wtc_pkg;
    typedef enum logic { WTC_MODE_OVER_UNDER, WTC_MODE_FILLING } wtc_mode_t;
    typedef enum logic [1:0] { WTC_TOL_EXACT, WTC_TOL_DEV, WTC_TOL_PCT, WTC_TOL_RSVD }
        wtc_tol_t;
    typedef enum logic [1:0] { WTC_Z_NONE, WTC_Z_UNDER, WTC_Z_OK, WTC_Z_OVER } wtc_zone_t;
endpackage
`default_nettype wire

/* File: logic/wtc_limit_calc.sv */
// limit calculator: turns target and tolerances into upper/lower limits
// assumes inputs are stable register values; purely combinational
`include "wtc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wtc_limit_calc
(
    input  wire logic [1:0]            i_tol_type, // tolerance type code
    input  wire logic [`WTC_WT_W-1:0]  i_target,   // target weight
    input  wire logic [`WTC_TOL_W-1:0] i_tol_pos,  // + tol or over limit
    input  wire logic [`WTC_TOL_W-1:0] i_tol_neg,  // - tol or under limit
    output logic      [`WTC_WT_W+1:0]  o_hi,       // upper limit, inclusive
    output logic      [`WTC_WT_W+1:0]  o_lo        // lower limit, inclusive
);
    logic [39:0] pct_pos;
    logic [39:0] pct_neg;

    // percent band, the division truncates toward zero
    always_comb
    begin
        pct_pos = (40'(i_target) * 40'(i_tol_pos)) / `WTC_PCT_DIV; // RULE8 RULE14
        pct_neg = (40'(i_target) * 40'(i_tol_neg)) / `WTC_PCT_DIV; // RULE8 RULE14
    end

    // limits kept 2 bits wider so target plus a fixed tolerance never wraps; the percent term is cut to 26 bits and can wrap
    always_comb
    begin
        case (wtc_pkg::wtc_tol_t'(i_tol_type))
            wtc_pkg::WTC_TOL_EXACT:
            begin
                o_hi = 26'(i_tol_pos); // RULE5
                o_lo = 26'(i_tol_neg); // RULE6
            end
            wtc_pkg::WTC_TOL_PCT:
            begin
                o_hi = 26'(i_target) + pct_pos[25:0]; // RULE8
                o_lo = 26'(i_target) - pct_neg[25:0]; // RULE8
            end
            default:
            begin
                o_hi = 26'(i_target) + 26'(i_tol_pos); // RULE7 RULE14
                o_lo = 26'(i_target) - 26'(i_tol_neg); // RULE7 RULE14
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: logic/wtc_compare.sv */
// zone comparator: places a signed weight against inclusive limits
// assumes limits are 26-bit two's complement (a lower limit may go negative)
`timescale 1ns/1ps
`default_nettype none
module wtc_compare
(
    input  wire logic [25:0] i_wt, // signed compared weight
    input  wire logic [25:0] i_hi, // signed upper limit
    input  wire logic [25:0] i_lo, // signed lower limit
    output var wtc_pkg::wtc_zone_t o_zone // resulting zone
);
    // over is tested first so in an inverted band a weight above the upper limit reports over, not under
    always_comb
    begin
        if ($signed(i_wt) > $signed(i_hi))
            o_zone = wtc_pkg::WTC_Z_OVER;  // RULE3 RULE5
        else if ($signed(i_wt) < $signed(i_lo))
            o_zone = wtc_pkg::WTC_Z_UNDER; // RULE4 RULE6
        else
            o_zone = wtc_pkg::WTC_Z_OK;    // RULE2
    end
endmodule
`default_nettype wire

/* File: logic/wtc_top.sv */
// weight tolerance classifier top: registers, record loading, zone outputs
// assumes weights and motion flag are synchronous to i_mclk
// assumes the register master never raises both strobes together
`include "wtc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wtc_top
(
    input  wire logic                   i_mclk,     // 200 MHz clock
    input  wire logic                   i_rst,      // sync reset, high
    input  wire logic [`WTC_ADDR_W-1:0] i_addr,     // register byte address
    input  wire logic [`WTC_DATA_W-1:0] i_wdata,    // register write data
    input  wire logic                   i_wr,       // write strobe
    input  wire logic                   i_rd,       // read strobe
    output logic      [`WTC_DATA_W-1:0] o_rdata,    // read data, next cycle
    input  wire logic [`WTC_WT_W:0]     i_net_wt,   // signed net weight
    input  wire logic [`WTC_WT_W:0]     i_gross_wt, // signed gross weight
    input  wire logic                   i_motion,   // scale in motion
    input  wire logic                   i_show_trk, // discrete display request
    output logic                        o_under,    // under output
    output logic                        o_ok,       // tolerance ok output
    output logic                        o_over,     // over output
    output logic                        o_show_trk, // display request seen
    output logic                        o_irq       // level interrupt
);
    // ----------------
    // staging record, edited by software
    // ----------------
    logic [4:0]            ctrl_reg;
    logic [`WTC_WT_W-1:0]  target_reg;
    logic [`WTC_TOL_W-1:0] tol_pos_reg;
    logic [`WTC_TOL_W-1:0] tol_neg_reg;

    // ----------------
    // active record, used by the comparison
    // ----------------
    logic [4:0]            act_ctrl_reg;
    logic [`WTC_WT_W-1:0]  act_target_reg;
    logic [`WTC_TOL_W-1:0] act_tol_pos_reg;
    logic [`WTC_TOL_W-1:0] act_tol_neg_reg;
    logic                  active_reg;

    // ----------------
    // classification and interrupt state
    // ----------------
    wtc_pkg::wtc_zone_t zone_reg;
    wtc_pkg::wtc_zone_t zone_next;
    logic [2:0]         irq_st_reg;
    logic [2:0]         irq_st_next;
    logic [2:0]         irq_msk_reg;
    logic [2:0]         zone_set;
    logic [2:0]         next_bits;
    logic               show_trk_reg;

    // ----------------
    // decoded strobes
    // ----------------
    logic wr_ctrl;
    logic wr_target;
    logic wr_pos;
    logic wr_neg;
    logic wr_load;
    logic wr_msk;
    logic rd_irq;
    logic load_go;
    logic load_clr;

    // ----------------
    // comparison datapath
    // ----------------
    logic [`WTC_WT_W:0] src_wt;
    logic [`WTC_WT_W:0] abs_wt;
    logic [25:0]        cmp_wt;
    logic [25:0]        lim_hi;
    logic [25:0]        lim_lo;
    wtc_pkg::wtc_zone_t cmp_zone;
    logic               mode_fill;
    logic               gate_open;

    // ----------------
    // functions
    // ----------------

    // address match, used by every strobe decode
    function automatic logic hit
    (
        input logic [`WTC_ADDR_W-1:0] addr,
        input logic [`WTC_ADDR_W-1:0] ofs
    );
        hit = (addr == ofs);
    endfunction

    // one-hot {over, ok, under} for a zone, shared by outputs and events
    function automatic logic [2:0] zone_bits
    (
        input wtc_pkg::wtc_zone_t z
    );
        case (z)
            wtc_pkg::WTC_Z_UNDER: zone_bits = 3'h1;
            wtc_pkg::WTC_Z_OK:    zone_bits = 3'h2;
            wtc_pkg::WTC_Z_OVER:  zone_bits = 3'h4;
            default:              zone_bits = 3'h0;
        endcase
    endfunction

    // ----------------
    // register port decode
    // ----------------

    // unmapped addresses are simply ignored on write
    assign wr_ctrl   = i_wr & hit(i_addr, `WTC_OFS_CTRL);
    assign wr_target = i_wr & hit(i_addr, `WTC_OFS_TARGET);
    assign wr_pos    = i_wr & hit(i_addr, `WTC_OFS_TOL_POS);
    assign wr_neg    = i_wr & hit(i_addr, `WTC_OFS_TOL_NEG);
    assign wr_load   = i_wr & hit(i_addr, `WTC_OFS_LOAD);
    assign wr_msk    = i_wr & hit(i_addr, `WTC_OFS_IRQ_MSK);
    assign rd_irq    = i_rd & hit(i_addr, `WTC_OFS_IRQ_ST);
    assign load_go   = wr_load & i_wdata[`WTC_LOAD_GO];
    assign load_clr  = wr_load & i_wdata[`WTC_LOAD_CLR];

    // ----------------
    // staging record registers
    // ----------------

    // control: mode, tolerance type, source, motion check
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            ctrl_reg <= `WTC_CTRL_RST;
        else if (wr_ctrl)
            ctrl_reg <= i_wdata[4:0];
    end

    // target and tolerance fields
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            target_reg  <= '0;
            tol_pos_reg <= '0;
            tol_neg_reg <= '0;
        end
        else
        begin
            if (wr_target)
                target_reg <= i_wdata[`WTC_WT_W-1:0];
            if (wr_pos)
                tol_pos_reg <= i_wdata[`WTC_TOL_W-1:0];
            if (wr_neg)
                tol_neg_reg <= i_wdata[`WTC_TOL_W-1:0];
        end
    end

    // ----------------
    // record loading
    // ----------------

    // a load copies the whole staging record at once, so the comparison
    // never runs on a half-edited record; clear wins over load
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            act_ctrl_reg    <= `WTC_CTRL_RST;
            act_target_reg  <= '0;
            act_tol_pos_reg <= '0;
            act_tol_neg_reg <= '0;
            active_reg      <= 1'b0;
        end
        else if (load_clr)
            active_reg <= 1'b0;
        else if (load_go)
        begin
            act_ctrl_reg    <= ctrl_reg;
            act_target_reg  <= target_reg;
            act_tol_pos_reg <= tol_pos_reg;
            act_tol_neg_reg <= tol_neg_reg;
            active_reg      <= 1'b1; // RULE1
        end
    end

    // ----------------
    // weight selection
    // ----------------

    assign mode_fill = (act_ctrl_reg[`WTC_CTRL_MODE] == 1'(wtc_pkg::WTC_MODE_FILLING));

    // source per record, then absolute value in filling mode
    always_comb
    begin
        src_wt = act_ctrl_reg[`WTC_CTRL_SRC] ? i_gross_wt : i_net_wt; // RULE11
        if (src_wt[`WTC_WT_W])
            abs_wt = (~src_wt) + 25'h0000001;
        else
            abs_wt = src_wt;
        // over/under keeps the sign so a negative load classifies as under
        if (mode_fill)
            cmp_wt = {1'b0, abs_wt}; // RULE2 RULE12
        else
            cmp_wt = {src_wt[`WTC_WT_W], src_wt}; // RULE12
    end

    // ----------------
    // limits and comparison
    // ----------------

    // exact limits only mean something in over/under mode; filling
    // treats that code as a plain target deviation
    logic [1:0] eff_tol;
    always_comb
    begin
        eff_tol = act_ctrl_reg[`WTC_CTRL_TOL_HI:`WTC_CTRL_TOL_LO];
        if (mode_fill && eff_tol == 2'(wtc_pkg::WTC_TOL_EXACT))
            eff_tol = 2'(wtc_pkg::WTC_TOL_DEV); // RULE12
    end

    wtc_limit_calc u_limit
    (
        .i_tol_type (eff_tol),
        .i_target   (act_target_reg),
        .i_tol_pos  (act_tol_pos_reg),
        .i_tol_neg  (act_tol_neg_reg),
        .o_hi       (lim_hi),
        .o_lo       (lim_lo)
    );

    wtc_compare u_cmp
    (
        .i_wt   (cmp_wt),
        .i_hi   (lim_hi),
        .i_lo   (lim_lo),
        .o_zone (cmp_zone)
    );

    // ----------------
    // motion gating and zone register
    // ----------------

    // with the check on, a moving scale blanks all three outputs
    assign gate_open = ~(act_ctrl_reg[`WTC_CTRL_MCHK] & i_motion); // RULE9 RULE10

    // re-evaluated every clock while a record is active, no start needed
    always_comb
    begin
        if (!active_reg)
            zone_next = wtc_pkg::WTC_Z_NONE;
        else if (!gate_open)
            zone_next = wtc_pkg::WTC_Z_NONE; // RULE9
        else
            zone_next = cmp_zone; // RULE1 RULE10
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            zone_reg <= wtc_pkg::WTC_Z_NONE;
        else
            zone_reg <= zone_next;
    end

    // ----------------
    // discrete outputs
    // ----------------

    // one-hot decode of the next zone, shared by outputs and events
    assign next_bits = zone_bits(zone_next);

    // outputs are registered one-hot from the next zone, so at most one is high
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_under <= 1'b0;
            o_ok    <= 1'b0;
            o_over  <= 1'b0;
        end
        else
        begin
            o_under <= next_bits[0]; // RULE4 RULE6
            o_ok    <= next_bits[1]; // RULE2
            o_over  <= next_bits[2]; // RULE3 RULE5
        end
    end

    // discrete display request is only passed on for the display logic
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            show_trk_reg <= 1'b0;
        else
            show_trk_reg <= i_show_trk; // RULE13
    end
    assign o_show_trk = show_trk_reg;

    // ----------------
    // interrupts
    // ----------------

    // an event is entry into a zone that differs from the last one
    assign zone_set = (zone_next != zone_reg) ? next_bits : 3'h0;

    // sticky bits, a read clears them but a same-cycle entry survives
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_irq
            always_comb
            begin
                if (zone_set[gi])
                    irq_st_next[gi] = 1'b1;
                else if (rd_irq)
                    irq_st_next[gi] = 1'b0;
                else
                    irq_st_next[gi] = irq_st_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            irq_st_reg <= 3'h0;
        else
            irq_st_reg <= irq_st_next;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            irq_msk_reg <= 3'h0;
        else if (wr_msk)
            irq_msk_reg <= i_wdata[2:0];
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_st_next & irq_msk_reg);
    end

    // ----------------
    // read data
    // ----------------

    // data stands one cycle after the strobe and is zero otherwise
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_rdata <= '0;
        else if (!i_rd)
            o_rdata <= '0;
        else
        begin
            case (i_addr)
                `WTC_OFS_CTRL:    o_rdata <= 32'(ctrl_reg);
                `WTC_OFS_TARGET:  o_rdata <= 32'(target_reg);
                `WTC_OFS_TOL_POS: o_rdata <= 32'(tol_pos_reg);
                `WTC_OFS_TOL_NEG: o_rdata <= 32'(tol_neg_reg);
                `WTC_OFS_STATUS:
                    o_rdata <= {26'h0, i_motion, active_reg, zone_bits(zone_reg)};
                `WTC_OFS_IRQ_ST:  o_rdata <= 32'(irq_st_reg);
                `WTC_OFS_IRQ_MSK: o_rdata <= 32'(irq_msk_reg);
                default:          o_rdata <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: bench/wtc_top_asserts.sv */
// checker beside the classifier top: zone, read port and irq relations
// assumes only the top ports are visible; record state is shadowed here
`include "wtc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wtc_chk
(
    input wire logic        i_mclk,     // clock
    input wire logic        i_rst,      // sync reset
    input wire logic [7:0]  i_addr,     // address
    input wire logic [31:0] i_wdata,    // write data
    input wire logic        i_wr,       // write strobe
    input wire logic        i_rd,       // read strobe
    input wire logic [31:0] o_rdata,    // read data
    input wire logic [24:0] i_net_wt,   // net weight
    input wire logic [24:0] i_gross_wt, // gross weight
    input wire logic        i_motion,   // motion
    input wire logic        i_show_trk, // display key
    input wire logic        o_under,    // under
    input wire logic        o_ok,       // ok
    input wire logic        o_over,     // over
    input wire logic        o_show_trk, // key copy
    input wire logic        o_irq       // interrupt
);
    // ----------------------------------------------------------
    // record shadow
    // ----------------------------------------------------------
    logic       act_reg; // record active
    logic       mst_reg; // staged motion check
    logic       mck_reg; // motion check in use
    logic [2:0] msk_reg; // irq mask
    logic [2:0] zone;    // {over, ok, under}
    assign zone = {o_over, o_ok, o_under};
    // mask starts all ones so an unknown reset value cannot misfire
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            act_reg <= 1'b0;
            mst_reg <= 1'b0;
            mck_reg <= 1'b0;
            msk_reg <= 3'h7;
        end
        else if (i_wr && i_addr == `WTC_OFS_CTRL)
            mst_reg <= i_wdata[`WTC_CTRL_MCHK];
        else if (i_wr && i_addr == `WTC_OFS_IRQ_MSK)
            msk_reg <= i_wdata[2:0];
        else if (i_wr && i_addr == `WTC_OFS_LOAD)
        begin
            act_reg <= i_wdata[`WTC_LOAD_CLR] ? 1'b0 : (i_wdata[`WTC_LOAD_GO] | act_reg);
            mck_reg <= i_wdata[`WTC_LOAD_GO] ? mst_reg : mck_reg;
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    a_zone_onehot: assert property ($onehot0(zone))
        else $error("more than one zone output high");
    a_idle_blank: assert property (!$past(act_reg) |-> zone == 3'h0)
        else $error("zone output without an active record");
    a_motion_blank: assert property ($past(act_reg) && $past(mck_reg) && $past(i_motion)
        |-> zone == 3'h0)
        else $error("zone output while moving with motion check");
    a_zone_live: assert property ($past(act_reg) && !($past(mck_reg) && $past(i_motion))
        |-> $onehot(zone))
        else $error("no zone output for an active record");
    a_zone_hold: assert property (!$past(i_wr) && $stable(i_net_wt) && $stable(i_gross_wt)
        && $stable(i_motion) |=> $stable(zone))
        else $error("zone changed with steady inputs");
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_rd_zero: assert property ($past(i_rd) && ($past(i_addr) > 8'h1c
        || $past(i_addr) == `WTC_OFS_LOAD) |-> o_rdata == 32'h0)
        else $error("unmapped or load read not zero");
    a_irq_entry: assert property ($changed(zone) && (zone & msk_reg) != 3'h0
        |-> ##[0:1] o_irq)
        else $error("unmasked zone entry without interrupt");
    a_irq_masked: assert property (o_irq |-> $past(msk_reg) != 3'h0
        || $past(msk_reg, 2) != 3'h0)
        else $error("interrupt with all events masked");
    a_key_copy: assert property (!$past(i_rst) |-> o_show_trk == $past(i_show_trk))
        else $error("display request not passed on");
endmodule
bind wtc_top wtc_chk i_wtc_chk
(
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_net_wt(i_net_wt),
    .i_gross_wt(i_gross_wt), .i_motion(i_motion), .i_show_trk(i_show_trk),
    .o_under(o_under), .o_ok(o_ok), .o_over(o_over), .o_show_trk(o_show_trk),
    .o_irq(o_irq)
);
`default_nettype wire

/* File: bench/wtc_lamp_model.sv */
// far side: reject gate counting over entries, and the display key panel
// assumes lamp and key lines are sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module wtc_lamp_model
(
    input  wire logic       i_mclk,   // clock
    input  wire logic       i_rst,    // sync reset
    input  wire logic       i_over,   // over lamp / reject drive
    input  wire logic       i_key,    // operator key, from bench
    output logic            o_show,   // discrete display request
    output logic      [7:0] o_rejects // reject actuations
);
    logic over_reg; // last over level
    // a reject fires once per entry, not per cycle held
    always_ff @(posedge i_mclk)
    begin
        over_reg  <= i_over;
        o_rejects <= i_rst ? 8'h00 : o_rejects + {7'h0, i_over & ~over_reg};
    end
    // key contact passes one sampling flop, like a real input
    always_ff @(posedge i_mclk)
        o_show <= i_key;
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the weight tolerance classifier
// assumes design, lamp model and checker files are compiled before it
`include "wtc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_mclk, i_rst, i_wr, i_rd, i_motion, i_show_trk, key;
    logic        o_under, o_ok, o_over, o_show_trk, o_irq;
    logic [7:0]  i_addr, rejects, rej0;
    logic [31:0] i_wdata, o_rdata, rdv;
    logic [24:0] i_net_wt, i_gross_wt;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;

    wtc_top i_wtc_top
    (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_net_wt(i_net_wt),
        .i_gross_wt(i_gross_wt), .i_motion(i_motion), .i_show_trk(i_show_trk),
        .o_under(o_under), .o_ok(o_ok), .o_over(o_over), .o_show_trk(o_show_trk),
        .o_irq(o_irq)
    );
    wtc_lamp_model i_wtc_lamp_model
    (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_over(o_over), .i_key(key),
        .o_show(i_show_trk), .o_rejects(rejects)
    );

    always #2.5 i_mclk = ~i_mclk;
    // ceiling far above the few hundred cycles the sequence needs
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    // ----------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        rdv = o_rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdv, exp);
    endtask
    // blank the old record first so no half-written setup is ever live
    task automatic cfg(input logic [4:0] c, input logic [23:0] t, input logic [23:0] p,
                       input logic [23:0] n);
        wr(`WTC_OFS_LOAD, 32'h2);
        wr(`WTC_OFS_CTRL, {27'h0, c});
        wr(`WTC_OFS_TARGET, {8'h0, t});
        wr(`WTC_OFS_TOL_POS, {8'h0, p});
        wr(`WTC_OFS_TOL_NEG, {8'h0, n});
        wr(`WTC_OFS_LOAD, 32'h1);
    endtask
    // zone expectation is {over, ok, under}
    task automatic tw(input logic [24:0] n, input logic [24:0] g, input logic [2:0] exp);
        @(posedge i_mclk);
        i_net_wt   <= n;
        i_gross_wt <= g;
        repeat (3) @(posedge i_mclk);
        #1;
        chk({29'h0, o_over, o_ok, o_under}, {29'h0, exp});
    endtask
    task automatic tx(input logic [24:0] w, input logic [2:0] exp);
        tw(w, w, exp);
    endtask
    // both inclusive edges and one step past each
    task automatic band(input logic [24:0] lo, input logic [24:0] hi);
        tx(lo - 25'h1, 3'h1);
        tx(lo, 3'h2);
        tx(hi, 3'h2);
        tx(hi + 25'h1, 3'h4);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        i_mclk = 1'b0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_motion = 1'b0;
        key = 1'b0;
        i_net_wt = 25'h0;
        i_gross_wt = 25'h0;
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        rc(`WTC_OFS_CTRL, 32'h0);
        rc(`WTC_OFS_STATUS, 32'h0);
        wr(`WTC_OFS_IRQ_MSK, 32'h7);
        // exact limits, then deviation, code 3, percent
        rej0 = rejects;
        cfg(5'h00, 24'h0, 24'h3e8, 24'h384);
        band(25'h384, 25'h3e8);
        tx(-25'h5, 3'h1);
        chk({24'h0, rejects - rej0}, 32'h1);
        cfg(5'h02, 24'h1f4, 24'h5, 24'h2);
        band(25'h1f2, 25'h1f9);
        tx(-25'h1f2, 3'h1);
        tw(25'h1fa, 25'h1f4, 3'h4);
        cfg(5'h02, 24'h3e8, 24'h5, 24'h2);
        band(25'h3e6, 25'h3ed);
        cfg(5'h06, 24'h1f4, 24'h5, 24'h2);
        band(25'h1f2, 25'h1f9);
        cfg(5'h04, 24'h64, 24'h5, 24'h2);
        band(25'h62, 25'h69);
        cfg(5'h04, 24'hc8, 24'h5, 24'h2);
        band(25'hc4, 25'hd2);
        cfg(5'h04, 24'h96, 24'h5, 24'h3);
        band(25'h92, 25'h9d);
        // filling compares the magnitude of the weight, then gross source in over/under
        cfg(5'h03, 24'h1f4, 24'h5, 24'h2);
        band(25'h1f2, 25'h1f9);
        tx(-25'h1f4, 3'h2);
        tx(-25'h1fa, 3'h4);
        cfg(5'h0a, 24'h1f4, 24'h5, 24'h2);
        tw(25'h1f4, 25'h1fa, 3'h4);
        tw(25'h1fa, 25'h1f4, 3'h2);
        // motion check on, then off while moving
        cfg(5'h12, 24'h1f4, 24'h5, 24'h2);
        @(posedge i_mclk);
        i_motion <= 1'b1;
        tx(25'h1fa, 3'h0);
        rc(`WTC_OFS_STATUS, 32'h18);
        @(posedge i_mclk);
        i_motion <= 1'b0;
        tx(25'h1fa, 3'h4);
        cfg(5'h02, 24'h1f4, 24'h5, 24'h2);
        @(posedge i_mclk);
        i_motion <= 1'b1;
        band(25'h1f2, 25'h1f9);
        @(posedge i_mclk);
        i_motion <= 1'b0;
        // interrupt: raise, clear by read, mask
        tx(25'h1f4, 3'h2);
        rd(`WTC_OFS_IRQ_ST);
        repeat (2) @(posedge i_mclk);
        #1;
        chk({31'h0, o_irq}, 32'h0);
        tx(25'h1fa, 3'h4);
        chk({31'h0, o_irq}, 32'h1);
        rc(`WTC_OFS_IRQ_ST, 32'h4);
        rc(`WTC_OFS_IRQ_ST, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        wr(`WTC_OFS_IRQ_MSK, 32'h0);
        tx(25'h1f1, 3'h1);
        chk({31'h0, o_irq}, 32'h0);
        rc(`WTC_OFS_IRQ_ST, 32'h1);
        wr(`WTC_OFS_IRQ_MSK, 32'h7);
        // unmapped place, write-only load, staged target
        rc(8'h20, 32'h0);
        wr(8'h20, 32'hffffffff);
        rc(`WTC_OFS_CTRL, 32'h2);
        rc(`WTC_OFS_LOAD, 32'h0);
        rc(`WTC_OFS_TARGET, 32'h1f4);
        // deactivate wins over load, then reload
        wr(`WTC_OFS_LOAD, 32'h3);
        tx(25'h1f4, 3'h0);
        rc(`WTC_OFS_STATUS, 32'h0);
        wr(`WTC_OFS_LOAD, 32'h1);
        tx(25'h1f4, 3'h2);
        @(posedge i_mclk);
        key <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        chk({31'h0, o_show_trk}, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
